// ===== bench/bss_chk_properties.sv
// Port checker for the stepper sequencer.
// Bound into bss_sequencer; one clock, async reset.
`timescale 1ns/1ps
`default_nettype none
module bss_chk (
   input wire logic clk,
   input wire logic arst_n,
   input wire logic stepClock,
   input wire logic rotation_direction_select,
   input wire logic step_size_select,
   input wire logic idle_coil_impedance_select,
   input wire logic biasOpen,
   input wire logic biasReduced,
   input wire bss_pkg::bss_bridge_t bridge,
   input wire logic currentReduce,
   input wire logic first_phase_indicator_n
);
   wire logic [7:0] b = bridge;
   wire logic on = b != 8'h0;
   default clocking @(posedge clk);
   endclocking
   default disable iff (!arst_n);
   AST_OPEN_OFF:
      assert property (biasOpen [*4] |-> !on) else $error("open not off");
   AST_OPEN_IND:
      assert property (biasOpen [*4] |-> !first_phase_indicator_n)
      else $error("open ind high");
   AST_IND:
      assert property (on |-> ((b == 8'h99) == !first_phase_indicator_n))
      else $error("ind mismatch");
   AST_STEP:
      assert property (!biasOpen [*6] ##0 $rose(stepClock) |->
         ##[1:5] $changed(b))
      else $error("no step");
   AST_RESUME:
      assert property (biasOpen [*4] ##1 !biasOpen |-> ##[1:6] b == 8'h99)
      else $error("no resume");
   AST_REDUCE:
      assert property ((biasReduced && !biasOpen) [*4] |-> currentReduce)
      else $error("no reduce");
   AST_FULL:
      assert property (!step_size_select [*8] ##0 $changed(b) && on |->
         b[7:4] inside {4'h9, 4'h6} && b[3:0] inside {4'h9, 4'h6})
      else $error("full coil off");
   AST_IDLE_HI:
      assert property ((step_size_select && idle_coil_impedance_select) [*5]
         ##0 on |-> b[7:4] != 4'h0 && b[3:0] != 4'h0)
      else $error("idle not high");
   cover property ($rose(stepClock) && step_size_select);
   cover property ($fell(biasOpen));
   cover property (currentReduce && on);
endmodule
bind bss_sequencer bss_chk i_chk (.*);
`default_nettype wire

// ===== bench/bss_sequencer_test.sv
// Self-checking bench for the stepper sequencer.
// Partner model makes the step clock and the bias line.
`timescale 1ns/1ps
`default_nettype none
module bss_sequencer_test;
   logic clk = 0, arst_n = 0, stepReq = 0, openReq = 1, busy;
   logic rotation_direction_select = 0, step_size_select = 0;
   logic idle_coil_impedance_select = 0, biasReduced = 0;
   logic stepClock, biasOpen, currentReduce, first_phase_indicator_n;
   bss_pkg::bss_bridge_t bridge;
   int n_errors = 0, n_compared = 0;
   // Rows: direction, half, idle-high, phase after step
   logic [5:0] rows [15] = '{6'h11, 6'h12, 6'h1b, 6'h1c, 6'h1d, 6'h34,
      6'h33, 6'h3a, 6'h04, 6'h0e, 6'h00, 6'h26, 6'h00, 6'h3f, 6'h10};
   bss_sequencer i_bss_sequencer (.*);
   bss_step_ctrl i_bss_step_ctrl (.*);
   initial forever #4 clk = ~clk;
   function automatic logic [3:0] leg(logic [1:0] c, logic hi);
      return c == 2'h1 ? 4'h9 : c == 2'h2 ? 4'h6 : {hi, 1'b0, hi, 1'b0};
   endfunction
   function automatic logic [7:0] expBr(logic [2:0] p, logic hi);
      logic [15:0] c1 = 16'h52a1, c2 = 16'h2a15;
      return {leg(c1[2*p+:2], hi), leg(c2[2*p+:2], hi)};
   endfunction
   task automatic chk(string nm, logic [7:0] seen, logic [7:0] exp);
      n_compared++;
      if (seen !== exp) begin
         n_errors++;
         $display("BAD %s exp %h seen %h", nm, exp, seen);
      end
   endtask
   task automatic finish_test;
      $display("errors %0d compared %0d", n_errors, n_compared);
      if (n_errors == 0 && n_compared > 0) $display("RESULT: PASS");
      else $display("RESULT: FAIL");
      $finish;
   endtask
   // Timed from the model's busy flag, sampled off the edge
   task automatic step(logic [2:0] c);
      int i;
      @(posedge clk);
      {rotation_direction_select, step_size_select,
         idle_coil_impedance_select} <= c;
      repeat (2) @(posedge clk);
      stepReq <= 1;
      @(posedge clk);
      stepReq <= 0;
      @(negedge clk);
      for (i = 0; i < 30 && busy !== 1'b0; i++) @(negedge clk);
      if (i == 30) begin
         n_errors++;
         finish_test;
      end
   endtask
   initial begin
      repeat (16) @(posedge clk);
      arst_n <= 1;
      repeat (4) @(posedge clk);
      openReq <= 0;
      repeat (8) @(negedge clk);
      chk("start", bridge, 8'h99);
      foreach (rows[k]) begin
         step(rows[k][5:3]);
         chk("bridge", bridge,
             expBr(rows[k][2:0], &rows[k][4:3]));
         chk("ind", first_phase_indicator_n, rows[k][2:0] != 0);
      end
      step(3'h2);
      chk("pre", bridge, expBr(3'h1, 1'b0));
      @(posedge clk);
      openReq <= 1;
      step(3'h2);
      chk("open", bridge, 8'h0);
      chk("openInd", first_phase_indicator_n, 1'b0);
      @(posedge clk);
      openReq <= 0;
      biasReduced <= 1;
      step(3'h2);
      chk("reduce", currentReduce, 1'b1);
      chk("resume", bridge, expBr(3'h1, 1'b0));
      finish_test;
   end
endmodule
`default_nettype wire

// ===== bench/bss_step_ctrl.sv
// Step controller model: step pulses and the bias/set line.
// Bench clock domain; pulse widths well over three cycles.
`timescale 1ns/1ps
`default_nettype none
module bss_step_ctrl (
   input  wire logic clk,
   input  wire logic arst_n,
   input  wire logic stepReq,
   input  wire logic openReq,
   output var  logic stepClock,
   output var  logic biasOpen,
   output var  logic busy
);
   logic [3:0] cnt_q;
   assign busy = cnt_q != 4'h0;
   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         cnt_q <= 4'h0;
         stepClock <= 1'b0;
         biasOpen <= 1'b1;
      end else begin
         biasOpen <= openReq;
         stepClock <= busy ? cnt_q > 4'h4 : stepReq;
         cnt_q <= busy ? cnt_q - 4'h1 : {stepReq, 3'h0};
      end
   end
endmodule
`default_nettype wire

// ===== rtl/bss_pkg.sv
// Package for the bipolar stepper sequencer: phase tables, bus types.
// Assumes a single 125 MHz clock domain.
package bss_pkg;
   localparam int CLK_MHZ = 125;
   localparam int NUM_PHASES = 8;
   localparam logic [2:0] PHASE_A = 3'h0;
   localparam logic [2:0] FULL_STEP_INC = 3'h2;
   localparam logic [2:0] HALF_STEP_INC = 3'h1;

   // Pin synchroniser: six sampled inputs, bias bit resets to open
   localparam int         SYNC_BITS  = 6;
   localparam logic [5:0] SYNC_RESET = 6'h10;

   // One output leg: high-side and low-side switch enables
   typedef struct packed {
      logic hiOn;
      logic loOn;
   } bss_leg_t;

   typedef struct packed {
      bss_leg_t coilOneP;
      bss_leg_t coilOneN;
      bss_leg_t coilTwoP;
      bss_leg_t coilTwoN;
   } bss_bridge_t;

   // Coil drive per phase: 2'b01 forward, 2'b10 reverse, 2'b00 idle
   typedef struct packed {
      logic [1:0] coilOne;
      logic [1:0] coilTwo;
   } bss_drive_t;

   localparam logic [1:0] DRV_FWD  = 2'h1;
   localparam logic [1:0] DRV_REV  = 2'h2;
   localparam logic [1:0] DRV_IDLE = 2'h0;

   // Half-step table; even entries double as full-step A..D
   localparam bss_drive_t PHASE_TABLE [NUM_PHASES] = '{
      '{DRV_FWD,  DRV_FWD},
      '{DRV_IDLE, DRV_FWD},
      '{DRV_REV,  DRV_FWD},
      '{DRV_REV,  DRV_IDLE},
      '{DRV_REV,  DRV_REV},
      '{DRV_IDLE, DRV_REV},
      '{DRV_FWD,  DRV_REV},
      '{DRV_FWD,  DRV_IDLE}
   };
endpackage

// ===== rtl/bss_sequencer.sv
// Phase sequencer and bridge decoder for a two-phase bipolar stepper.
// Assumes step clock and control levels arrive asynchronously from a
// controller; biasOpen and biasReduced come from the bias sense circuit.
// Functional notes
// - Each step clock rising edge moves outputs to the next state
// - High impedance output means both switches off
// - Direction select picks forward or backward stepping
// - Step size low: four full-step phases A to D
// - Full step energizes both coils in every phase it steps to
// - Step size high: eight half-step phases A to H
// - Half phases A,C,E,G match full phases A,B,C,D
// - Half phases B,D,F,H drive one coil only
// - Idle impedance select matters only in half-step mode
// - Idle select low: idle coil legs fully off
// - Idle select high: idle coil legs high side on, low off
// - Bias open: hold phase A, all outputs high impedance
// - Bias open: phase A indicator driven low
// - Bias open: control inputs ignored
// - Bias restored: outputs enable in phase A pattern (next phase if a step edge comes in the same cycle), then respond
// - Reduced bias cuts current but keeps phase state
// - Step clock edges ignored while bias open
// - Phase A indicator low in phase A pattern and while bias open
`timescale 1ns/1ps
`default_nettype none
module bss_sequencer (
   input  wire logic          clk,
   input  wire logic          arst_n,
   input  wire logic          stepClock,
   input  wire logic          rotation_direction_select,
   input  wire logic          step_size_select,
   input  wire logic          idle_coil_impedance_select,
   input  wire logic          biasOpen,
   input  wire logic          biasReduced,
   output var  bss_pkg::bss_bridge_t bridge,
   output logic               currentReduce,
   output logic               first_phase_indicator_n
);
   // Two-stage synchronisers for all pin inputs
   logic [5:0] syncA_q;
   logic [5:0] syncB_q;
   logic [5:0] syncA_d;
   logic [5:0] syncB_d;
   logic       clkPrev_q;
   logic       clkPrev_d;
   logic [2:0] phase_q;
   logic [2:0] phase_d;
   bss_pkg::bss_bridge_t bridge_q;
   bss_pkg::bss_bridge_t bridge_d;
   logic       reduce_q;
   logic       reduce_d;
   logic       indN_q;
   logic       indN_d;

   logic sClk;
   logic sDir;
   logic sHalf;
   logic sIdleHi;
   logic sOpen;
   logic sReduced;
   logic stepEdge;
   logic [2:0] stepInc;

   function automatic bss_pkg::bss_leg_t legDrive(input logic hi,
                                                   input logic lo);
      bss_pkg::bss_leg_t l;
      l.hiOn = hi;
      l.loOn = lo;
      return l;
   endfunction

   // Drive one coil's leg pair from its table entry
   function automatic logic [3:0] coilLegs(input logic [1:0] drv,
                                           input logic idleHi);
      logic [3:0] r;
      r = 4'h0;
      unique case (drv)
         bss_pkg::DRV_FWD: r = {legDrive(1'b1, 1'b0), legDrive(1'b0, 1'b1)};
         bss_pkg::DRV_REV: r = {legDrive(1'b0, 1'b1), legDrive(1'b1, 1'b0)};
         default: begin
            if (idleHi) begin
               r = {legDrive(1'b1, 1'b0), legDrive(1'b1, 1'b0)};
            end else begin
               r = 4'h0;
            end
         end
      endcase
      return r;
   endfunction

   // Phase after one step edge; full step from an odd phase moves a
   // single half step, so later full steps land on two-coil phases
   function automatic logic [2:0] nextPhase(input logic [2:0] cur,
                                            input logic       back,
                                            input logic       half,
                                            input logic [2:0] inc);
      logic [2:0] amt;
      logic [2:0] fwd;
      logic [2:0] bwd;
      amt = inc;
      if (!half && cur[0]) begin
         amt = bss_pkg::HALF_STEP_INC;
      end
      fwd = cur + amt;
      bwd = cur - amt;
      return back ? bwd : fwd;
   endfunction

   // True only for the phase A polarity on both coils, so the
   // indicator follows the outputs themselves
   function automatic logic isPhaseAPattern(
         input bss_pkg::bss_bridge_t br);
      logic ok;
      ok = 1'b1;
      ok = ok & br.coilOneP.hiOn & ~br.coilOneP.loOn;
      ok = ok & ~br.coilOneN.hiOn & br.coilOneN.loOn;
      ok = ok & br.coilTwoP.hiOn & ~br.coilTwoP.loOn;
      ok = ok & ~br.coilTwoN.hiOn & br.coilTwoN.loOn;
      return ok;
   endfunction

   // Sampled pin levels, named by what they control
   assign sClk     = syncB_q[0];
   assign sDir     = syncB_q[1];
   assign sHalf    = syncB_q[2];
   assign sIdleHi  = syncB_q[3];
   assign sOpen    = syncB_q[4];
   assign sReduced = syncB_q[5];

   always_comb begin
      syncA_d = {biasReduced, biasOpen, idle_coil_impedance_select,
                 step_size_select, rotation_direction_select, stepClock};
      syncB_d = syncA_q;
   end

   // Every pin is asynchronous to clk, so each bit gets two flops.
   // The bias bit resets to open, keeping outputs off until sampled.
   for (genvar gi = 0; gi < bss_pkg::SYNC_BITS; gi++) begin : gSync
      always_ff @(posedge clk or negedge arst_n) begin
         if (!arst_n) begin
            syncA_q[gi] <= bss_pkg::SYNC_RESET[gi];
            syncB_q[gi] <= bss_pkg::SYNC_RESET[gi];
         end else begin
            syncA_q[gi] <= syncA_d[gi];
            syncB_q[gi] <= syncB_d[gi];
         end
      end
   end

   // Edge detector; previous level resets low like the idle pin,
   // so releasing reset never fakes a step
   always_comb begin
      clkPrev_d = sClk;
   end

   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         clkPrev_q <= 1'b0;
      end else begin
         clkPrev_q <= clkPrev_d;
      end
   end

   assign stepEdge = sClk & ~clkPrev_q;
   assign stepInc  = sHalf ? bss_pkg::HALF_STEP_INC
                           : bss_pkg::FULL_STEP_INC;

   // Phase state; open bias wins over any step edge
   always_comb begin
      phase_d = phase_q;
      if (sOpen) begin
         phase_d = bss_pkg::PHASE_A;
      end else if (stepEdge) begin
         phase_d = nextPhase(phase_q, sDir, sHalf, stepInc);
      end
   end

   // Reset doubles as bias open, so the state starts at phase A
   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         phase_q <= bss_pkg::PHASE_A;
      end else begin
         phase_q <= phase_d;
      end
   end

   // Decode from the next phase so bridge and state move together
   always_comb begin
      bss_pkg::bss_drive_t drv;
      logic                idleHi;
      drv    = bss_pkg::PHASE_TABLE[phase_d];
      idleHi = sIdleHi & sHalf;
      if (sOpen) begin
         bridge_d = '0;
      end else begin
         bridge_d = {coilLegs(drv.coilOne, idleHi),
                     coilLegs(drv.coilTwo, idleHi)};
      end
   end

   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         bridge_q <= '0;
      end else begin
         bridge_q <= bridge_d;
      end
   end

   // Reduced bias only lowers current; phase is untouched
   always_comb begin
      reduce_d = sReduced & ~sOpen;
   end

   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         reduce_q <= 1'b0;
      end else begin
         reduce_q <= reduce_d;
      end
   end

   // Low in the phase A pattern, and also while bias is open
   always_comb begin
      if (sOpen) begin
         indN_d = 1'b0;
      end else begin
         indN_d = ~isPhaseAPattern(bridge_d);
      end
   end

   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         indN_q <= 1'b0;
      end else begin
         indN_q <= indN_d;
      end
   end

   assign bridge                  = bridge_q;
   assign currentReduce           = reduce_q;
   assign first_phase_indicator_n = indN_q;
endmodule
`default_nettype wire
